// file: hw/pdp_parser.sv
/*
  Descriptor word parser: assembles bytes into pulse and timed control
  descriptors, decodes header and flags, hands fields to the scheduler.
  Assumes bytes arrive in word order on a valid/ready stream and that
  software programs format and lengths while the run bit is clear.
*/
// Decided for this implementation: the register addresses and the strobed register port.
// Behaviour
// - Words assembled from an ordered byte stream
// - Type decided only from header/flag bits
// - Word length and layout follow decoded type
// - Kind flag: clear pulse, set timed control
// - Pulse word: realtime pulse or stored replay
// - Control word retunes or rearms playback
// - Pulse word: header, flags, body, payload
// - Params or extension only in expert format
// - Format fixed for a whole run
// - Format set by local or remote configuration
// - Header 48 bits basic, 56 bits expert
// - Timestamp 44 bits basic, 52 expert
// - Source flag: zero stored, one realtime
// - Expert-only extension present flag
// - Expert two-bit parameter select field
// - Basic header has three reserved bits
// - Flags section is eight bits
// - Phase flag selects absolute or relative phase
// - Suppressed pulse accepted, no output
// - Markers one to three; fourth ignored
// - Words arrive over a network link
// - Extension present drops the params block
`timescale 1ns/100ps
module pdp_parser
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [pdp_pkg::AW-1:0] reg_addr,
  input wire logic [pdp_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pdp_pkg::DW-1:0] reg_rdata,
  // Byte stream from the link endpoint
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Descriptor to the playback scheduler
  output logic desc_valid,
  output logic desc_kind,
  output logic [pdp_pkg::TOA_W-1:0] arrival_timestamp,
  output logic waveform_source_flag,
  output logic ext_present,
  output logic [1:0] param_select,
  output logic phase_reference_flag,
  output logic [15:0] phase_value_field,
  output logic suppress_output_flag,
  // Derived playback controls
  output logic signal_start,
  output logic control_start,
  output logic [15:0] applied_phase,
  output logic marker_one_flag,
  output logic marker_two_flag,
  output logic marker_three_flag
);
  import pdp_pkg::*;

  pdp_state_t st;
  logic run;
  logic cfg_expert;
  logic fmt;
  logic [7:0] tcd_len;
  logic [6:0] ext_len;
  logic [7:0] cnt;
  logic [7:0] last_q;
  logic [55:0] sh;
  logic [31:0] pd_cnt;
  logic [31:0] tcd_cnt;
  logic kind_q;
  logic src_q;
  logic ext_q;
  logic [1:0] par_q;
  logic phs_q;
  logic supp_q;
  logic [2:0] mk_q;
  logic [15:0] phs_val;
  logic [TOA_W-1:0] toa_q;
  logic acc;
  logic [7:0] flags_idx;
  logic at_flags;
  logic at_last;
  logic [7:0] next_last;
  logic [7:0] tcd_last;
  logic [7:0] tcd_min;

  assign acc = in_valid && in_ready;
  assign flags_idx = fmt ? FLAGS_IDX_EXPERT : FLAGS_IDX_BASIC;
  assign at_flags = (st == PDP_S_HEAD) && (cnt == flags_idx);
  assign at_last = (st == PDP_S_BODY) && (cnt == last_q);

  // Control words never end on the flags byte, keeps delivery in one place
  always_comb
  begin
    tcd_min = flags_idx + 8'h01;
    tcd_last = tcd_len - 8'h01;
    if (tcd_last < tcd_min)
    begin
      tcd_last = tcd_min;
    end
    if (in_data[FLG_KIND])
    begin
      next_last = tcd_last;
    end
    else if (fmt && sh[HDR_EXT])
    begin
      next_last = PD_EXT_BASE + {1'b0, ext_len};
    end
    else
    begin
      next_last = PD_LAST_IDX;
    end
  end

  // Register writes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      run <= 1'b0;
      cfg_expert <= 1'b0;
      tcd_len <= TCD_LEN_RST;
      ext_len <= EXT_LEN_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        run <= reg_wdata[CTRL_RUN];
        cfg_expert <= reg_wdata[CTRL_EXPERT];
      end
      else if (reg_addr == ADDR_TCD_LEN)
      begin
        tcd_len <= reg_wdata[7:0];
      end
      else if (reg_addr == ADDR_EXT_LEN)
      begin
        ext_len <= reg_wdata[6:0];
      end
    end
  end

  // Active format only follows configuration while stopped
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fmt <= 1'b0;
      in_ready <= 1'b0;
    end
    else
    begin
      in_ready <= run;
      if (!run)
      begin
        fmt <= cfg_expert;
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        reg_rdata <= {30'h00000000, cfg_expert, run};
      end
      else if (reg_addr == ADDR_TCD_LEN)
      begin
        reg_rdata <= {24'h000000, tcd_len};
      end
      else if (reg_addr == ADDR_EXT_LEN)
      begin
        reg_rdata <= {25'h0000000, ext_len};
      end
      else if (reg_addr == ADDR_STATUS)
      begin
        reg_rdata <= {30'h00000000, (st == PDP_S_BODY) || (cnt != 8'h00), fmt};
      end
      else if (reg_addr == ADDR_PD_CNT)
      begin
        reg_rdata <= pd_cnt;
      end
      else if (reg_addr == ADDR_TCD_CNT)
      begin
        reg_rdata <= tcd_cnt;
      end
      else
      begin
        reg_rdata <= '0;
      end
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

  // Byte counter and framing state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st <= PDP_S_HEAD;
      cnt <= 8'h00;
      last_q <= PD_LAST_IDX;
    end
    else if (acc)
    begin
      case (st)
        PDP_S_HEAD:
        begin
          cnt <= cnt + 8'h01;
          if (at_flags)
          begin
            last_q <= next_last;
            st <= PDP_S_BODY;
          end
        end
        PDP_S_BODY:
        begin
          if (at_last)
          begin
            cnt <= 8'h00;
            st <= PDP_S_HEAD;
          end
          else
          begin
            cnt <= cnt + 8'h01;
          end
        end
        default:
        begin
          st <= PDP_S_HEAD;
        end
      endcase
    end
  end

  // Header shift, most significant byte first
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sh <= '0;
    end
    else if (acc && (st == PDP_S_HEAD) && !at_flags)
    begin
      sh <= {sh[47:0], in_data};
    end
  end

  // Field decode on the flags byte; reserved bits are dropped here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      kind_q <= 1'b0;
      src_q <= 1'b0;
      ext_q <= 1'b0;
      par_q <= 2'b00;
      phs_q <= 1'b0;
      supp_q <= 1'b0;
      mk_q <= 3'b000;
      toa_q <= '0;
    end
    else if (acc && at_flags)
    begin
      kind_q <= in_data[FLG_KIND];
      src_q <= sh[HDR_SRC];
      phs_q <= in_data[FLG_PHASE];
      supp_q <= in_data[FLG_SUPP];
      mk_q <= {in_data[FLG_M3], in_data[FLG_M2], in_data[FLG_M1]};
      if (fmt)
      begin
        toa_q <= sh[TOA_MSB_EXPERT:TOA_LSB];
        ext_q <= sh[HDR_EXT];
        par_q <= sh[HDR_PAR_HI:HDR_PAR_LO];
      end
      else
      begin
        toa_q <= {8'h00, sh[TOA_MSB_BASIC:TOA_LSB]};
        ext_q <= 1'b0;
        par_q <= 2'b00;
      end
    end
  end

  // Phase value from the body
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phs_val <= 16'h0000;
    end
    else if (acc && (st == PDP_S_BODY) && !kind_q)
    begin
      if (cnt == flags_idx + PHS_HI_OFS)
      begin
        phs_val[15:8] <= in_data;
      end
      else if (cnt == flags_idx + PHS_LO_OFS)
      begin
        phs_val[7:0] <= in_data;
      end
    end
  end

  // Delivery to the scheduler, one word per pulse, in arrival order
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      desc_valid <= 1'b0;
      desc_kind <= 1'b0;
      arrival_timestamp <= '0;
      waveform_source_flag <= 1'b0;
      ext_present <= 1'b0;
      param_select <= 2'b00;
      phase_reference_flag <= 1'b0;
      phase_value_field <= 16'h0000;
      suppress_output_flag <= 1'b0;
    end
    else
    begin
      desc_valid <= acc && at_last;
      if (acc && at_last)
      begin
        desc_kind <= kind_q;
        arrival_timestamp <= toa_q;
        waveform_source_flag <= src_q;
        ext_present <= ext_q;
        param_select <= par_q;
        phase_reference_flag <= phs_q;
        phase_value_field <= phs_val;
        suppress_output_flag <= supp_q;
      end
    end
  end

  // Playback controls
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      signal_start <= 1'b0;
      control_start <= 1'b0;
      applied_phase <= 16'h0000;
      marker_one_flag <= 1'b0;
      marker_two_flag <= 1'b0;
      marker_three_flag <= 1'b0;
    end
    else
    begin
      signal_start <= acc && at_last && !kind_q && !supp_q;
      control_start <= acc && at_last && kind_q;
      if (acc && at_last && !kind_q && !supp_q)
      begin
        // Relative mode wraps modulo one turn
        applied_phase <= phs_q ? applied_phase + phs_val : phs_val;
        marker_one_flag <= mk_q[0];
        marker_two_flag <= mk_q[1];
        marker_three_flag <= mk_q[2];
      end
    end
  end

  // Word counters
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pd_cnt <= 32'h00000000;
      tcd_cnt <= 32'h00000000;
    end
    else if (acc && at_last)
    begin
      if (kind_q)
      begin
        tcd_cnt <= tcd_cnt + 32'h00000001;
      end
      else
      begin
        pd_cnt <= pd_cnt + 32'h00000001;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_last_byte;
    acc && at_last;
  endsequence

  sequence s_flags_byte;
    acc && at_flags;
  endsequence

  property p_count;
    acc && !at_last && !at_flags |=> cnt == $past(cnt) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("byte count slip");

  property p_kind;
    s_flags_byte ##1 (!acc || !at_last)[*1] |-> kind_q == $past(in_data[FLG_KIND]);
  endproperty
  a_kind: assert property (p_kind) else $error("kind not from flags");

  property p_deliver;
    s_last_byte |=> desc_valid && cnt == 8'h00;
  endproperty
  a_deliver: assert property (p_deliver) else $error("word end not delivered");

  property p_pd_len;
    s_flags_byte and (!in_data[FLG_KIND] && !(fmt && sh[HDR_EXT]))
      |=> last_q == PD_LAST_IDX;
  endproperty
  a_pd_len: assert property (p_pd_len) else $error("pulse length wrong");

  property p_fmt;
    run && $past(run) |-> $stable(fmt);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format changed in run");

  property p_basic;
    desc_valid && !fmt |-> arrival_timestamp[51:44] == 8'h00 && !ext_present
      && param_select == 2'b00;
  endproperty
  a_basic: assert property (p_basic) else $error("basic word has expert fields");

  property p_suppress;
    desc_valid && suppress_output_flag |-> !signal_start;
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppressed word played");

  property p_marker;
    signal_start |-> marker_one_flag == $past(mk_q[0]) && marker_three_flag == $past(mk_q[2]);
  endproperty
  a_marker: assert property (p_marker) else $error("marker mismatch");

  property p_order;
    s_last_byte |=> pd_cnt + tcd_cnt == $past(pd_cnt) + $past(tcd_cnt) + 32'h00000001;
  endproperty
  a_order: assert property (p_order) else $error("word lost");
endmodule

// file: hw/pdp_pkg.sv
/*
  Constants, register map and types for the descriptor word parser.
  Assumes one 50 MHz clock and a big-endian byte stream, MSB field first.
*/
package pdp_pkg;
  localparam int CLK_HZ = 50000000;
  // Register bus
  localparam int AW = 4;
  localparam int DW = 32;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TCD_LEN = 4'h1;
  localparam logic [3:0] ADDR_EXT_LEN = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_PD_CNT = 4'h4;
  localparam logic [3:0] ADDR_TCD_CNT = 4'h5;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXPERT = 1;
  localparam int STAT_FMT = 0;
  localparam int STAT_BUSY = 1;
  localparam logic [7:0] TCD_LEN_RST = 8'h10;
  localparam logic [6:0] EXT_LEN_RST = 7'h10;
  // Byte index of the flags byte equals the header length in bytes
  localparam logic [7:0] FLAGS_IDX_BASIC = 8'h06;
  localparam logic [7:0] FLAGS_IDX_EXPERT = 8'h07;
  // Pulse word: 32 bytes in either format; 28 plus extension otherwise
  localparam logic [7:0] PD_LAST_IDX = 8'h1F;
  localparam logic [7:0] PD_EXT_BASE = 8'h1B;
  // Body phase bytes, relative to the flags byte
  localparam logic [7:0] PHS_HI_OFS = 8'h07;
  localparam logic [7:0] PHS_LO_OFS = 8'h08;
  // Header fields (low end of the header shift register)
  localparam int TOA_W = 52;
  localparam int TOA_LSB = 4;
  localparam int TOA_MSB_BASIC = 47;
  localparam int TOA_MSB_EXPERT = 55;
  localparam int HDR_SRC = 3;
  localparam int HDR_EXT = 2;
  localparam int HDR_PAR_HI = 1;
  localparam int HDR_PAR_LO = 0;
  // Flags byte
  localparam int FLG_KIND = 7;
  localparam int FLG_PHASE = 5;
  localparam int FLG_SUPP = 4;
  localparam int FLG_M4 = 3;
  localparam int FLG_M3 = 2;
  localparam int FLG_M2 = 1;
  localparam int FLG_M1 = 0;
  typedef enum logic {PDP_S_HEAD, PDP_S_BODY} pdp_state_t;
endpackage

// file: test/pdp_host_model.sv
/*
  Host model: streams descriptor bytes from a queue over valid/ready.
  Assumes the bench fills the queue in word order and drives stall.
*/
`timescale 1ns/100ps
module pdp_host_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Byte stream
  input wire logic stall,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data
);
  logic [7:0] q[$];
  // Idle data inverted so a stale byte never passes for a fresh one
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      in_valid <= 1'b0;
      in_data <= 8'h00;
    end
    else if (!in_valid || in_ready)
    begin
      if (q.size() > 0 && !stall)
      begin
        in_valid <= 1'b1;
        in_data <= q.pop_front();
      end
      else
      begin
        in_valid <= 1'b0;
        in_data <= ~in_data;
      end
    end
  end
endmodule

// file: test/tb_pdp_parser.sv
/*
  Testbench: register access, basic and expert words, control words.
  Assumes the host model streams the bytes that the tasks queue.
*/
`timescale 1ns/100ps
module tb_pdp_parser;
  import pdp_pkg::*;
  typedef struct {logic k; logic [51:0] ts; logic s; logic e; logic [1:0] p; logic pr;
    logic sp; logic ss; logic cs; logic [15:0] ph; logic [15:0] ap; logic [2:0] mk;} pdp_exp_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
  logic in_valid, in_ready, desc_valid, desc_kind, waveform_source_flag, ext_present;
  logic phase_reference_flag, suppress_output_flag, signal_start, control_start;
  logic marker_one_flag, marker_two_flag, marker_three_flag;
  logic [7:0] in_data;
  logic [51:0] arrival_timestamp;
  logic [1:0] param_select;
  logic [15:0] phase_value_field, applied_phase, aph = 16'h0;
  logic [2:0] mk = 3'h0;
  logic [31:0] lfsr = 32'h8DE9;
  logic [4:0] cyc = 5'h00;
  int error_cnt = 0, checks_done = 0, n_pd = 0, n_tc = 0, ext_len = 16, tcd_len = 16;
  pdp_exp_t eq[$];
  pdp_exp_t mx;

  pdp_parser u_pdp_parser (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .in_valid, .in_data, .in_ready, .desc_valid, .desc_kind,
    .arrival_timestamp, .waveform_source_flag, .ext_present, .param_select,
    .phase_reference_flag, .phase_value_field, .suppress_output_flag, .signal_start,
    .control_start, .applied_phase, .marker_one_flag, .marker_two_flag, .marker_three_flag);
  pdp_host_model u_pdp_host_model (.clk, .sys_rst, .stall, .in_ready, .in_valid, .in_data);

  always #10 clk = ~clk;

  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0);
    return lfsr;
  endfunction

  // Host stalls on a pseudo-random pattern
  always @(posedge clk)
  begin
    cyc <= cyc + 5'h01;
    stall <= lfsr[cyc];
  end

  task cmp(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp(reg_rdata, e);
    @(negedge clk);
    cmp(reg_rdata, 32'h0);
  endtask

  task send(input logic ex, input logic s, input logic e, input logic [1:0] p,
            input logic [7:0] f);
    logic [55:0] h;
    logic [51:0] ts;
    logic [15:0] ph;
    int hl;
    int n;
    pdp_exp_t x;
    ts = {rnd(), 20'(rnd())};
    ph = 16'(rnd());
    hl = ex ? 7 : 6;
    h = ex ? {ts, s, e, p} : {8'h00, ts[43:0], s, 3'b000};
    n = f[7] ? tcd_len : (ex && e) ? 28 + ext_len : 32;
    for (int i = 0; i < n; i++)
      u_pdp_host_model.q.push_back(i < hl ? h[8*(hl-1-i)+:8] : i == hl ? f :
        i == hl + 7 ? ph[15:8] : i == hl + 8 ? ph[7:0] : 8'(rnd()));
    x.k = f[7];
    x.ts = ex ? ts : {8'h00, ts[43:0]};
    x.s = s;
    x.e = ex & e;
    x.p = ex ? p : 2'b00;
    x.pr = f[5];
    x.sp = f[4];
    x.ss = !f[7] && !f[4];
    x.cs = f[7];
    x.ph = ph;
    if (x.ss)
    begin
      aph = f[5] ? aph + ph : ph;
      mk = f[2:0];
    end
    x.ap = aph;
    x.mk = mk;
    if (f[7])
      n_tc++;
    else
      n_pd++;
    eq.push_back(x);
  endtask

  task idle();
    int t;
    t = 0;
    while ((u_pdp_host_model.q.size() > 0 || in_valid || eq.size() > 0) && t < 3000)
    begin
      @(posedge clk);
      t++;
    end
    cmp(eq.size(), 0);
    repeat (2) @(posedge clk);
  endtask

  always @(negedge clk)
    if (!sys_rst && desc_valid === 1'b1)
    begin
      if (eq.size() == 0)
        cmp(1, 0);
      else
      begin
        mx = eq.pop_front();
        cmp(desc_kind, mx.k);
        cmp(signal_start, mx.ss);
        cmp(control_start, mx.cs);
        cmp({marker_three_flag, marker_two_flag, marker_one_flag}, mx.mk);
        cmp(applied_phase, mx.ap);
        if (!mx.k)
        begin
          cmp(arrival_timestamp, mx.ts);
          cmp(waveform_source_flag, mx.s);
          cmp({ext_present, param_select}, {mx.e, mx.p});
          cmp({phase_reference_flag, suppress_output_flag}, {mx.pr, mx.sp});
          cmp(phase_value_field, mx.ph);
        end
      end
    end

  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_TCD_LEN, 32'(TCD_LEN_RST));
    rd(ADDR_EXT_LEN, 32'(EXT_LEN_RST));
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS, 32'h0);
    wr(4'h9, 32'hFFFF_FFFF);
    rd(4'h9, 32'h0);
    $display("test registers done");
    // Basic words, random flags incl. the reserved marker bit
    for (int i = 0; i < 10; i++)
      send(1'b0, lfsr[9], 1'b0, 2'b00, {2'b00, 6'(rnd())});
    send(1'b0, 1'b0, 1'b0, 2'b00, 8'h80);
    send(1'b0, 1'b1, 1'b0, 2'b00, 8'h07);
    idle();
    rd(ADDR_PD_CNT, 32'(n_pd));
    rd(ADDR_TCD_CNT, 32'(n_tc));
    $display("test basic done");
    // Format change held off while running
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    repeat (2) @(negedge clk);
    cmp(in_ready, 1'b0);
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_EXT_LEN, 32'h8);
    ext_len = 8;
    wr(ADDR_TCD_LEN, 32'h14);
    tcd_len = 20;
    rd(ADDR_TCD_LEN, 32'h14);
    rd(ADDR_EXT_LEN, 32'h8);
    for (int i = 0; i < 8; i++)
      send(1'b1, i[0], i[2], i[1:0], {2'b00, 6'(rnd())});
    send(1'b1, 1'b0, 1'b0, 2'b00, 8'h93);
    send(1'b1, 1'b1, 1'b1, 2'b01, 8'h21);
    idle();
    rd(ADDR_PD_CNT, 32'(n_pd));
    rd(ADDR_TCD_CNT, 32'(n_tc));
    $display("test expert done");
    complete_run();
  end
endmodule
